// file: logic/twd_pkg.sv
// Notes on behaviour
// - Host drives link clock; one shared two-way data line carries all traffic.
// - Eight-bit target select register, host-accessed, picks the data register.
// - Target select 0x02 routes data reads and writes to flash programming control.
// - Target select 0xB4 routes data reads and writes to flash programming data.
// - Target select 0x01 returns the revision code; reads only.
// - Target select zero returns the fixed eight-bit part code; read-only.
// - Revision code is read-only, eight bits, set by silicon revision.
// - These registers are reachable only over the debug link.
// - Writing 0x02 then 0x01 to control enables programming until system reset.
// - Data register carries flash commands 0x06, 0x07, 0x08, 0x03 and operands.
`default_nettype none
package twd_pkg;
  localparam logic [7:0] ADDR_PART = 8'h00;
  localparam logic [7:0] ADDR_REV = 8'h01;
  localparam logic [7:0] ADDR_FLASH_PROG_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_FLASH_PROG_DATA = 8'hB4;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] DAT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] UNLOCK_FIRST = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND = 8'h01;
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
  localparam logic [1:0] INS_DREAD = 2'h0;
  localparam logic [1:0] INS_DWRITE = 2'h1;
  localparam logic [1:0] INS_AREAD = 2'h2;
  localparam logic [1:0] INS_AWRITE = 2'h3;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int SYNC_DEPTH = 3;
  localparam int REF_SYNC_W = 3;
  localparam int LINK_SYNC_W = 2;
  typedef enum logic [1:0] {LS_IDLE, LS_INS, LS_WRITE, LS_READ} twd_link_state_t;
  typedef struct packed {
    logic valid;
    logic known_cmd;
    logic [7:0] data;
  } twd_flash_evt_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } twd_flash_ret_t;
endpackage : twd_pkg
`default_nettype wire

// file: logic/twd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module twd_sync
  import twd_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic en,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q2,
  output logic [WIDTH-1:0] q3
);
  logic [WIDTH-1:0] s1_r;
  // No reset: first stage carries no logic other than its enable
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (en) begin
        s1_r[i] <= d[i];
        q2[i] <= s1_r[i];
        q3[i] <= q2[i];
      end
    end
  end
endmodule : twd_sync
`default_nettype wire

// file: logic/twd_debug_regs.sv
`timescale 1ns/1ps
`default_nettype none
module twd_debug_regs
  import twd_pkg::*;
#(
  // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3C,
  // Arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'hA7
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic debug_clock_pin,
  input wire logic debug_data_in,
  output logic debug_data_out,
  output logic debug_data_oe,
  input wire twd_flash_ret_t flash_ret,
  output logic prog_mode,
  output twd_flash_evt_t flash_evt
);
  // Link domain state
  twd_link_state_t lst_r, lst_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic ins0_r, ins0_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] sel_r, sel_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] dat_r, dat_nxt;
  logic step_r, step_nxt;
  logic prog_lvl_r, prog_lvl_nxt;
  logic wr_tgl_r, wr_tgl_nxt;
  logic ret_seen_r, ret_seen_nxt;
  logic dout_nxt, doe_nxt;
  logic lrst_r;
  logic [LINK_SYNC_W-1:0] lsync2, lsync3;
  logic lrst;
  // Ref domain state
  logic armed_r, armed_nxt;
  logic prog_r, prog_nxt;
  logic wr_seen_r, wr_seen_nxt;
  logic ret_tgl_r, ret_tgl_nxt;
  logic [7:0] ret_byte_r, ret_byte_nxt;
  twd_flash_evt_t evt_nxt;
  logic [REF_SYNC_W-1:0] rsync2, rsync3;

  twd_sync #(.WIDTH(LINK_SYNC_W)) u_link_sync (
    .clk(debug_clock_pin),
    .en(1'b1),
    .d({ret_tgl_r, srst}),
    .q2(lsync2),
    .q3(lsync3)
  );

  twd_sync #(.WIDTH(REF_SYNC_W)) u_ref_sync (
    .clk(ref_clk),
    .en(ce),
    .d({lrst_r, wr_tgl_r, prog_lvl_r}),
    .q2(rsync2),
    .q3(rsync3)
  );

  // Reset reaches the link only while the host clocks it
  assign lrst = lsync2[0] & lsync3[0];

  // Byte returned for a read frame
  function automatic logic [7:0] read_word(input logic [1:0] ins);
    logic [7:0] w;
    w = UNMAPPED_READ;
    if (ins == INS_AREAD) begin
      w = sel_r;
    end else begin
      unique case (sel_r)
        ADDR_PART: w = PART_CODE;
        ADDR_REV: w = REVISION_CODE;
        ADDR_FLASH_PROG_CONTROL: w = ctl_r;
        ADDR_FLASH_PROG_DATA: w = dat_r;
        default: w = UNMAPPED_READ;
      endcase
    end
    return w;
  endfunction : read_word

  always_comb begin
    logic [7:0] byte_in;
    logic [1:0] ins;
    byte_in = {debug_data_in, sh_r[7:1]};
    ins = {debug_data_in, ins0_r};
    lst_nxt = lst_r;
    cnt_nxt = cnt_r;
    ins0_nxt = ins0_r;
    sh_nxt = sh_r;
    sel_nxt = sel_r;
    ctl_nxt = ctl_r;
    dat_nxt = dat_r;
    step_nxt = step_r;
    prog_lvl_nxt = prog_lvl_r;
    wr_tgl_nxt = wr_tgl_r;
    ret_seen_nxt = ret_seen_r;
    dout_nxt = debug_data_out;
    doe_nxt = debug_data_oe;
    // Returned flash byte; a host write in the same edge overrides it
    if (lsync2[1] == lsync3[1] && lsync3[1] != ret_seen_r) begin
      ret_seen_nxt = lsync3[1];
      dat_nxt = ret_byte_r;
    end
    unique case (lst_r)
      LS_IDLE: begin
        doe_nxt = 1'b0;
        if (!debug_data_in) begin
          lst_nxt = LS_INS;
          cnt_nxt = CNT_ZERO;
        end
      end
      LS_INS: begin
        if (cnt_r == CNT_ZERO) begin
          ins0_nxt = debug_data_in;
          cnt_nxt = CNT_ONE;
        end else begin
          cnt_nxt = CNT_ZERO;
          if (ins == INS_DREAD || ins == INS_AREAD) begin
            lst_nxt = LS_READ;
            sh_nxt = read_word(ins);
            dout_nxt = sh_nxt[0];
            doe_nxt = 1'b1;
          end else begin
            lst_nxt = LS_WRITE;
            // Keep high instruction bit for the commit
            ins0_nxt = ins[1];
          end
        end
      end
      LS_WRITE: begin
        sh_nxt = byte_in;
        if (cnt_r != LAST_BIT) begin
          cnt_nxt = cnt_r + CNT_ONE;
        end else begin
          lst_nxt = LS_IDLE;
          if (ins0_r == INS_AWRITE[1]) begin
            sel_nxt = byte_in;
          end else begin
            unique case (sel_r)
              ADDR_FLASH_PROG_CONTROL: begin
                ctl_nxt = byte_in;
                if (step_r && byte_in == UNLOCK_SECOND) begin
                  prog_lvl_nxt = 1'b1;
                end
                step_nxt = (byte_in == UNLOCK_FIRST);
              end
              ADDR_FLASH_PROG_DATA: begin
                dat_nxt = byte_in;
                wr_tgl_nxt = ~wr_tgl_r;
              end
              default: ;
            endcase
          end
        end
      end
      LS_READ: begin
        sh_nxt = sh_r >> 1;
        if (cnt_r != LAST_BIT) begin
          cnt_nxt = cnt_r + CNT_ONE;
          dout_nxt = sh_r[1];
        end else begin
          lst_nxt = LS_IDLE;
          doe_nxt = 1'b0;
        end
      end
    endcase
  end

  // registers live only behind the link
  always_ff @(posedge debug_clock_pin) begin
    lrst_r <= lrst;
    if (lrst) begin
      lst_r <= LS_IDLE;
      cnt_r <= CNT_ZERO;
      ins0_r <= 1'b0;
      sh_r <= DAT_RESET;
      sel_r <= SEL_RESET;
      ctl_r <= CTL_RESET;
      dat_r <= DAT_RESET;
      step_r <= 1'b0;
      prog_lvl_r <= 1'b0;
      wr_tgl_r <= 1'b0;
      ret_seen_r <= 1'b0;
      debug_data_out <= 1'b0;
      debug_data_oe <= 1'b0;
    end else begin
      lst_r <= lst_nxt;
      cnt_r <= cnt_nxt;
      ins0_r <= ins0_nxt;
      sh_r <= sh_nxt;
      sel_r <= sel_nxt;
      ctl_r <= ctl_nxt;
      dat_r <= dat_nxt;
      step_r <= step_nxt;
      prog_lvl_r <= prog_lvl_nxt;
      wr_tgl_r <= wr_tgl_nxt;
      ret_seen_r <= ret_seen_nxt;
      debug_data_out <= dout_nxt;
      debug_data_oe <= doe_nxt;
    end
  end

  always_comb begin
    logic stable_wr;
    stable_wr = (rsync2[1] == rsync3[1]);
    armed_nxt = armed_r;
    prog_nxt = prog_r;
    wr_seen_nxt = wr_seen_r;
    ret_tgl_nxt = ret_tgl_r;
    ret_byte_nxt = ret_byte_r;
    evt_nxt = flash_evt;
    evt_nxt.valid = 1'b0;
    // Stale link state ignored until the link shows its own reset
    if (!armed_r) begin
      wr_seen_nxt = rsync3[1];
      if (rsync2[2] && rsync3[2]) begin
        armed_nxt = 1'b1;
      end
    end else begin
      if (rsync2[0] && rsync3[0]) begin
        prog_nxt = 1'b1;
      end
      if (stable_wr && rsync3[1] != wr_seen_r) begin
        wr_seen_nxt = rsync3[1];
        evt_nxt.valid = 1'b1;
        // Byte is stable: host spacing outlasts the crossing
        evt_nxt.data = dat_r;
        evt_nxt.known_cmd = (dat_r == CMD_BLOCK_READ) ||
          (dat_r == CMD_BLOCK_WRITE) || (dat_r == CMD_PAGE_ERASE) ||
          (dat_r == CMD_DEVICE_ERASE);
      end
    end
    if (flash_ret.valid) begin
      ret_byte_nxt = flash_ret.data;
      ret_tgl_nxt = ~ret_tgl_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      armed_r <= 1'b0;
      prog_r <= 1'b0;
      wr_seen_r <= 1'b0;
      ret_tgl_r <= 1'b0;
      ret_byte_r <= DAT_RESET;
      flash_evt <= '0;
    end else if (ce) begin
      armed_r <= armed_nxt;
      prog_r <= prog_nxt;
      wr_seen_r <= wr_seen_nxt;
      ret_tgl_r <= ret_tgl_nxt;
      ret_byte_r <= ret_byte_nxt;
      flash_evt <= evt_nxt;
    end
  end

  always_comb prog_mode = prog_r;
endmodule : twd_debug_regs
`default_nettype wire

// file: verif/twd_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module twd_asserts
  import twd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic debug_clock_pin,
  input wire logic debug_data_in,
  input wire logic debug_data_out,
  input wire logic debug_data_oe,
  input wire twd_flash_ret_t flash_ret,
  input wire logic prog_mode,
  input wire twd_flash_evt_t flash_evt
);
  a_prog_sticky: assert property (@(posedge ref_clk) disable iff (srst)
    !$fell(prog_mode)) else $error("prog mode dropped");
  a_evt_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    flash_evt.valid |=> !flash_evt.valid [*4]) else $error("event too long");
  a_evt_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !flash_evt.valid |-> $stable(flash_evt.data)) else $error("event data moved");
  a_cmd_flag: assert property (@(posedge ref_clk) disable iff (srst)
    flash_evt.valid |-> flash_evt.known_cmd ==
    (flash_evt.data inside {8'h06, 8'h07, 8'h08, 8'h03})) else $error("bad flag");
  a_ce_freeze: assert property (@(posedge ref_clk) disable iff (srst)
    !ce |=> $stable(prog_mode) && $stable(flash_evt)) else $error("ce ignored");
  a_rd_len: assert property (@(posedge debug_clock_pin) disable iff (srst)
    $rose(debug_data_oe) |-> debug_data_oe [*8] ##1 !debug_data_oe)
    else $error("read drive length");
  a_rd_cause: assert property (@(posedge debug_clock_pin) disable iff (srst)
    $rose(debug_data_oe) |-> !$past(debug_data_in, 2) && !$past(debug_data_in, 3))
    else $error("drive without read");
  a_rd_gap: assert property (@(posedge debug_clock_pin) disable iff (srst)
    $fell(debug_data_oe) |-> !debug_data_oe [*3]) else $error("drive too soon");
endmodule : twd_asserts
`default_nettype wire

// file: verif/twd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module twd_host_model (
  output logic clk_o,
  output logic drv_o,
  input wire logic line_i
);
  initial begin
    clk_o = 1'b0;
    drv_o = 1'b1;
  end
  task automatic tick(input logic b);
    drv_o = b;
    #6 clk_o = 1'b1;
    #6 clk_o = 1'b0;
  endtask : tick
  // Line not driven by the target reads the host drive, held high during reads
  task automatic xfer(input logic [1:0] ins, input logic [7:0] d,
    output logic [7:0] q);
    q = 8'h00;
    tick(1'b0);
    tick(ins[0]);
    tick(ins[1]);
    for (int i = 0; i < 8; i++) begin
      if (!ins[0]) q[i] = line_i;
      tick(ins[0] ? d[i] : 1'b1);
    end
    repeat (2) tick(1'b1);
  endtask : xfer
endmodule : twd_host_model
`default_nettype wire

// file: verif/tb_twd_debug_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_twd_debug_regs
  import twd_pkg::*;
;
  typedef struct packed {logic [7:0] s; logic [7:0] w; logic [7:0] e;} twd_row_t;
  // Arbitrary values
  localparam logic [7:0] PC = 8'h5A;
  localparam logic [7:0] RC = 8'h1D;
  twd_row_t rows[5] = '{'{8'h00, 8'h55, PC}, '{8'h01, 8'h55, RC},
    '{8'h02, 8'h5A, 8'h5A}, '{8'hB4, 8'hC6, 8'hC6}, '{8'h33, 8'h77, 8'h00}};
  logic [7:0] cmds[5] = '{8'h06, 8'h07, 8'h08, 8'h03, 8'h09};
  logic ref_clk = 1'b0, srst = 1'b1, ce = 1'b1;
  logic dclk, hdrv, line, dout, doe, pm;
  logic [7:0] q;
  twd_flash_ret_t fret = '0;
  twd_flash_evt_t fev;
  int miscompares = 0, comparisons = 0, nev = 0;
  always #12.5 ref_clk = ~ref_clk;
  assign line = doe ? dout : hdrv;
  always @(negedge ref_clk) if (fev.valid) nev++;
  twd_debug_regs #(.PART_CODE(PC), .REVISION_CODE(RC)) twd_debug_regs_i (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .debug_clock_pin(dclk),
    .debug_data_in(line), .debug_data_out(dout), .debug_data_oe(doe),
    .flash_ret(fret), .prog_mode(pm), .flash_evt(fev));
  twd_host_model twd_host_model_i (.clk_o(dclk), .drv_o(hdrv), .line_i(line));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xf(input logic [1:0] ins, input logic [7:0] d);
    twd_host_model_i.xfer(ins, d, q);
  endtask : xf
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic rst;
    @(negedge ref_clk) srst = 1'b1;
    repeat (5) twd_host_model_i.tick(1'b1);
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    // Link leaves reset only after its synchroniser sees the release
    repeat (2) @(negedge ref_clk);
    repeat (4) twd_host_model_i.tick(1'b1);
  endtask : rst
  initial begin
    #2ms;
    miscompares++;
    close_out();
  end
  initial begin
    int n;
    rst();
    chk({7'h00, pm}, 8'h00);
    xf(INS_AREAD, 8'h00);
    chk(q, SEL_RESET);
    foreach (rows[i]) begin
      xf(INS_AWRITE, rows[i].s);
      xf(INS_DWRITE, rows[i].w);
      xf(INS_AREAD, 8'h00);
      chk(q, rows[i].s);
      xf(INS_DREAD, 8'h00);
      chk(q, rows[i].e);
    end
    xf(INS_AWRITE, ADDR_FLASH_PROG_DATA);
    foreach (cmds[i]) begin
      n = nev;
      xf(INS_DWRITE, cmds[i]);
      for (int k = 0; k < 40 && nev == n; k++) @(negedge ref_clk);
      repeat (8) @(negedge ref_clk);
      chk(nev[7:0], n[7:0] + 8'h01);
      chk(fev.data, cmds[i]);
      chk({7'h00, fev.known_cmd}, {7'h00, i < 4});
    end
    @(negedge ref_clk) fret = '{1'b1, 8'hE1};
    @(negedge ref_clk) fret.valid = 1'b0;
    repeat (4) twd_host_model_i.tick(1'b1);
    xf(INS_DREAD, 8'h00);
    chk(q, 8'hE1);
    xf(INS_AWRITE, ADDR_FLASH_PROG_CONTROL);
    xf(INS_DWRITE, UNLOCK_FIRST);
    xf(INS_DWRITE, 8'h05);
    xf(INS_DWRITE, UNLOCK_SECOND);
    repeat (20) @(negedge ref_clk);
    chk({7'h00, pm}, 8'h00);
    xf(INS_DWRITE, UNLOCK_FIRST);
    xf(INS_DWRITE, UNLOCK_SECOND);
    repeat (20) @(negedge ref_clk);
    chk({7'h00, pm}, 8'h01);
    xf(INS_AWRITE, ADDR_FLASH_PROG_DATA);
    n = nev;
    @(negedge ref_clk) ce = 1'b0;
    xf(INS_DWRITE, CMD_PAGE_ERASE);
    repeat (12) @(negedge ref_clk);
    chk(nev[7:0], n[7:0]);
    ce = 1'b1;
    repeat (12) @(negedge ref_clk);
    chk(nev[7:0], n[7:0] + 8'h01);
    chk(fev.data, CMD_PAGE_ERASE);
    rst();
    chk({7'h00, pm}, 8'h00);
    xf(INS_AREAD, 8'h00);
    chk(q, SEL_RESET);
    close_out();
  end
endmodule : tb_twd_debug_regs
bind twd_debug_regs twd_asserts twd_asserts_i (.ref_clk, .srst, .ce,
  .debug_clock_pin, .debug_data_in, .debug_data_out, .debug_data_oe,
  .flash_ret, .prog_mode, .flash_evt);
`default_nettype wire
